/* common/sev_pkg.sv */
package sev_pkg;

  // Register byte addresses on the supervisor access path
  localparam logic [31:0] OFF_FLAGS = 32'h000c_c448;
  localparam logic [31:0] OFF_IND_MASK = 32'h000c_c44c;
  localparam logic [31:0] OFF_IND_CLR = 32'h000c_c450;
  localparam logic [31:0] OFF_IND_SET = 32'h000c_c454;
  localparam logic [31:0] OFF_INT_VIEW = 32'h000c_c458;
  localparam logic [31:0] OFF_INT_MASK = 32'h000c_c45c;
  localparam logic [31:0] OFF_INT_CLR = 32'h000c_c460;
  localparam logic [31:0] OFF_INT_SET = 32'h000c_c464;
  localparam logic [31:0] OFF_BAD_ADDR = 32'h000c_c468;
  localparam logic [31:0] OFF_ENDIAN = 32'h000c_c520;

  // Field layout
  localparam int FIELD_LO = 16;
  localparam int FIELD_W = 16;
  localparam int RXP_N = 8;
  localparam int BAD_BIT = 29;
  localparam int TXM_LO = 30;
  localparam int TXM_N = 2;
  localparam int GAP_N = 5;
  localparam int ENDIAN_BIT = 31;
  localparam int BAD_ADDR_LO = 2;

  // Reset values
  localparam logic [15:0] IND_MASK_RST = 16'h0000;
  localparam logic [15:0] INT_MASK_RST = 16'hffff;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  function automatic logic [31:0] bswap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

endpackage

/* src/sev_event_report.sv */
// Behaviour
// - Eight live receive-pending bits at flag bit 16
// - Unmapped supervisor access sets bad-access flag
// - Writing one clears bad-access flag
// - Notified transmit packet sets its marked flag
// - Each marked flag cleared by writing one
// - Indication mask hides flag bits on read
// - Indication mask readable, changed only via set/clear
// - Clear register ones clear indication mask bits
// - Set register ones set indication mask bits
// - Interrupt view shows flags not interrupt-masked
// - Interrupt mask read-only, changed via set/clear
// - Byte-order bit selects big-endian bus data
// - Clear register ones clear interrupt mask bits
// - Set register ones set interrupt mask bits
// - Capture first bad address until flag cleared
`timescale 1ns/1ps
module sev_event_report (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sup_req,
  input wire logic sup_we,
  input wire logic [31:0] sup_addr,
  input wire logic [31:0] sup_wdata,
  input wire logic ext_hit,
  input wire logic [7:0] rx_pending,
  input wire logic [1:0] tx_mark_done,
  output logic sup_ack,
  output logic [31:0] sup_rdata,
  output logic irq,
  output logic big_endian
);

  logic sup_ack_reg;
  logic [31:0] sup_rdata_reg;
  logic irq_reg;
  logic endian_reg;
  logic bad_reg;
  logic bad_next;
  logic [1:0] txm_reg;
  logic [1:0] txm_next;
  logic [29:0] bad_addr_reg;
  logic [15:0] ind_mask_reg;
  logic [15:0] ind_mask_next;
  logic [15:0] int_mask_reg;
  logic [15:0] int_mask_next;

  logic take;
  logic wr;
  logic [31:0] wdata_le;
  logic [15:0] wfield;
  logic [15:0] raw_flags;
  logic [15:0] ind_view;
  logic [15:0] int_view;
  logic our_hit;
  logic bad_event;
  logic [31:0] rd_word;

  assign sup_ack = sup_ack_reg;
  assign sup_rdata = sup_rdata_reg;
  assign irq = irq_reg;
  assign big_endian = endian_reg;

  // A request is taken once; the host holds it until the acknowledge
  assign take = sup_req & ~sup_ack_reg;
  assign wr = take & sup_we;
  assign wdata_le = endian_reg ? sev_pkg::bswap(sup_wdata) : sup_wdata;
  assign wfield = wdata_le[sev_pkg::FIELD_LO +: sev_pkg::FIELD_W];

  // Pending bits are the FIFO levels themselves, so writes cannot touch them
  assign raw_flags = {txm_reg, bad_reg, {sev_pkg::GAP_N{1'b0}}, rx_pending};
  assign ind_view = raw_flags & ~ind_mask_reg;
  assign int_view = raw_flags & ~int_mask_reg;

  always_comb begin
    our_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (sup_addr)
      sev_pkg::OFF_FLAGS: begin
        rd_word[sev_pkg::FIELD_LO +: sev_pkg::FIELD_W] = ind_view;
      end
      sev_pkg::OFF_IND_MASK: begin
        rd_word[sev_pkg::FIELD_LO +: sev_pkg::FIELD_W] = ind_mask_reg;
      end
      sev_pkg::OFF_INT_VIEW: begin
        rd_word[sev_pkg::FIELD_LO +: sev_pkg::FIELD_W] = int_view;
      end
      sev_pkg::OFF_INT_MASK: begin
        rd_word[sev_pkg::FIELD_LO +: sev_pkg::FIELD_W] = int_mask_reg;
      end
      sev_pkg::OFF_BAD_ADDR: begin
        rd_word[31:sev_pkg::BAD_ADDR_LO] = bad_addr_reg;
      end
      sev_pkg::OFF_ENDIAN: begin
        rd_word[sev_pkg::ENDIAN_BIT] = endian_reg;
      end
      sev_pkg::OFF_IND_CLR, sev_pkg::OFF_IND_SET, sev_pkg::OFF_INT_CLR, sev_pkg::OFF_INT_SET: begin
        rd_word = 32'h0000_0000;
      end
      default: begin
        our_hit = 1'b0;
      end
    endcase
  end

  // Addresses claimed by other blocks of the device are not invalid
  assign bad_event = take & ~our_hit & ~ext_hit;

  // Bus answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sup_ack_reg <= 1'b0;
      sup_rdata_reg <= sev_pkg::RDATA_RST;
    end else begin
      sup_ack_reg <= take;
      if (take && !sup_we) begin
        sup_rdata_reg <= endian_reg ? sev_pkg::bswap(rd_word) : rd_word;
      end
    end
  end

  // Byte order control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      endian_reg <= 1'b0;
    end else if (wr && sup_addr == sev_pkg::OFF_ENDIAN) begin
      endian_reg <= wdata_le[sev_pkg::ENDIAN_BIT];
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_comb begin
    bad_next = bad_reg;
    txm_next = txm_reg;
    if (wr && sup_addr == sev_pkg::OFF_FLAGS) begin
      if (wdata_le[sev_pkg::BAD_BIT]) begin
        bad_next = 1'b0;
      end
      txm_next = txm_reg & ~wdata_le[sev_pkg::TXM_LO +: sev_pkg::TXM_N];
    end
    if (bad_event) begin
      bad_next = 1'b1;
    end
    txm_next = txm_next | tx_mark_done;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bad_reg <= 1'b0;
      txm_reg <= 2'b00;
    end else begin
      bad_reg <= bad_next;
      txm_reg <= txm_next;
    end
  end

  // Only the first bad address is kept, so the cause is not overwritten
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bad_addr_reg <= 30'h0000_0000;
    end else if (bad_event && !bad_reg) begin
      bad_addr_reg <= sup_addr[31:sev_pkg::BAD_ADDR_LO];
    end
  end

  // Masks change only through their set and clear locations
  always_comb begin
    ind_mask_next = ind_mask_reg;
    int_mask_next = int_mask_reg;
    if (wr) begin
      unique case (sup_addr)
        sev_pkg::OFF_IND_CLR: ind_mask_next = ind_mask_reg & ~wfield;
        sev_pkg::OFF_IND_SET: ind_mask_next = ind_mask_reg | wfield;
        sev_pkg::OFF_INT_CLR: int_mask_next = int_mask_reg & ~wfield;
        sev_pkg::OFF_INT_SET: int_mask_next = int_mask_reg | wfield;
        default: begin
          ind_mask_next = ind_mask_reg;
          int_mask_next = int_mask_reg;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ind_mask_reg <= sev_pkg::IND_MASK_RST;
      int_mask_reg <= sev_pkg::INT_MASK_RST;
    end else begin
      ind_mask_reg <= ind_mask_next;
      int_mask_reg <= int_mask_next;
    end
  end

  // Registered request; lags the view by one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |int_view;
    end
  end

  property p_rxp_read;
    @(posedge sys_clk) disable iff (rst)
    (take && !sup_we && sup_addr == sev_pkg::OFF_FLAGS && !endian_reg)
      |=> sup_rdata_reg[23:16] == $past(rx_pending & ~ind_mask_reg[7:0]);
  endproperty
  a_rxp_read: assert property (p_rxp_read) else $error("pending bits misread");

  property p_bad_set;
    @(posedge sys_clk) disable iff (rst)
    bad_event |=> bad_reg && sup_ack_reg;
  endproperty
  a_bad_set: assert property (p_bad_set) else $error("bad access not flagged");

  property p_bad_clr;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_FLAGS && wdata_le[sev_pkg::BAD_BIT]) |=> !bad_reg;
  endproperty
  a_bad_clr: assert property (p_bad_clr) else $error("bad flag not cleared");

  property p_zero_keeps;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_FLAGS && !wdata_le[sev_pkg::BAD_BIT] && bad_reg) |=> bad_reg;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

  property p_txm_set;
    @(posedge sys_clk) disable iff (rst)
    tx_mark_done[0] |=> txm_reg[0] ##1
      (txm_reg[0] || $past(wr && sup_addr == sev_pkg::OFF_FLAGS && wdata_le[sev_pkg::TXM_LO]));
  endproperty
  a_txm_set: assert property (p_txm_set) else $error("marked flag lost");

  property p_txm_clr;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_FLAGS && wdata_le[sev_pkg::TXM_LO + 1] && !tx_mark_done[1]) |=> !txm_reg[1];
  endproperty
  a_txm_clr: assert property (p_txm_clr) else $error("marked flag not cleared");

  property p_ind_clr;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_IND_CLR) |=> (ind_mask_reg & $past(wfield)) == 16'h0000;
  endproperty
  a_ind_clr: assert property (p_ind_clr) else $error("indication mask not cleared");

  property p_ind_set;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_IND_SET) |=> (ind_mask_reg & $past(wfield)) == $past(wfield);
  endproperty
  a_ind_set: assert property (p_ind_set) else $error("indication mask not set");

  property p_int_clr;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_INT_CLR) |=> (int_mask_reg & $past(wfield)) == 16'h0000;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt mask not cleared");

  property p_int_set;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_INT_SET) |=> (int_mask_reg & $past(wfield)) == $past(wfield);
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt mask not set");

  property p_mask_ro;
    @(posedge sys_clk) disable iff (rst)
    (wr && (sup_addr == sev_pkg::OFF_INT_MASK || sup_addr == sev_pkg::OFF_IND_MASK))
      |=> $stable(int_mask_reg) && $stable(ind_mask_reg);
  endproperty
  a_mask_ro: assert property (p_mask_ro) else $error("mask changed by view write");

  property p_addr_hold;
    @(posedge sys_clk) disable iff (rst)
    (bad_reg && bad_event) |=> $stable(bad_addr_reg);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("bad address overwritten");

  property p_irq;
    @(posedge sys_clk) disable iff (rst)
    (|int_view) |=> irq_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_off;
    @(posedge sys_clk) disable iff (rst)
    (int_view == 16'h0000) |=> !irq_reg;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt not dropped");

  property p_big;
    @(posedge sys_clk) disable iff (rst)
    (take && !sup_we && endian_reg) |=> sup_rdata_reg == sev_pkg::bswap($past(rd_word));
  endproperty
  a_big: assert property (p_big) else $error("read not byte swapped");

  // A new event must survive a clear written in the same cycle
  property p_txm_win;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_FLAGS && (tx_mark_done & wdata_le[sev_pkg::TXM_LO +: sev_pkg::TXM_N]) != 2'b00)
      |=> (txm_reg & $past(tx_mark_done)) == $past(tx_mark_done);
  endproperty
  a_txm_win: assert property (p_txm_win) else $error("event lost to clear");

  property p_ind_keep;
    @(posedge sys_clk) disable iff (rst)
    (wr && (sup_addr == sev_pkg::OFF_IND_CLR || sup_addr == sev_pkg::OFF_IND_SET))
      |=> (ind_mask_reg & ~$past(wfield)) == ($past(ind_mask_reg) & ~$past(wfield));
  endproperty
  a_ind_keep: assert property (p_ind_keep) else $error("unwritten indication mask bit moved");

  property p_int_keep;
    @(posedge sys_clk) disable iff (rst)
    (wr && (sup_addr == sev_pkg::OFF_INT_CLR || sup_addr == sev_pkg::OFF_INT_SET))
      |=> (int_mask_reg & ~$past(wfield)) == ($past(int_mask_reg) & ~$past(wfield));
  endproperty
  a_int_keep: assert property (p_int_keep) else $error("unwritten interrupt mask bit moved");

  property p_ind_hold;
    @(posedge sys_clk) disable iff (rst)
    !(wr && (sup_addr == sev_pkg::OFF_IND_CLR || sup_addr == sev_pkg::OFF_IND_SET)) |=> $stable(ind_mask_reg);
  endproperty
  a_ind_hold: assert property (p_ind_hold) else $error("indication mask changed without write");

  property p_int_hold;
    @(posedge sys_clk) disable iff (rst)
    !(wr && (sup_addr == sev_pkg::OFF_INT_CLR || sup_addr == sev_pkg::OFF_INT_SET)) |=> $stable(int_mask_reg);
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt mask changed without write");

  property p_view_read;
    @(posedge sys_clk) disable iff (rst)
    (take && !sup_we && sup_addr == sev_pkg::OFF_INT_VIEW && !endian_reg)
      |=> sup_rdata_reg[31:16] == $past(raw_flags & ~int_mask_reg);
  endproperty
  a_view_read: assert property (p_view_read) else $error("interrupt view misread");

  property p_addr_cap;
    @(posedge sys_clk) disable iff (rst)
    (bad_event && !bad_reg) |=> bad_addr_reg == $past(sup_addr[31:sev_pkg::BAD_ADDR_LO]);
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("first bad address not captured");

  // Unmapped reads must not leak the previous word
  property p_rd_zero;
    @(posedge sys_clk) disable iff (rst)
    (bad_event && !sup_we) |=> sup_rdata_reg == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");

  property p_endian_le;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_ENDIAN && !endian_reg) |=> endian_reg == $past(sup_wdata[sev_pkg::ENDIAN_BIT]);
  endproperty
  a_endian_le: assert property (p_endian_le) else $error("byte order write lost");

  // In big mode the control bit arrives in byte 0
  property p_endian_be;
    @(posedge sys_clk) disable iff (rst)
    (wr && sup_addr == sev_pkg::OFF_ENDIAN && endian_reg)
      |=> endian_reg == $past(sup_wdata[sev_pkg::ENDIAN_BIT - 24]);
  endproperty
  a_endian_be: assert property (p_endian_be) else $error("swapped byte order write lost");

endmodule // sev_event_report

/* sim/sev_host_model.sv */
`timescale 1ns/1ps
module sev_host_model (
  input wire logic sys_clk,
  input wire logic sup_ack,
  input wire logic [31:0] sup_rdata,
  output logic sup_req,
  output logic sup_we,
  output logic [31:0] sup_addr,
  output logic [31:0] sup_wdata
);
  initial begin
    sup_req = 1'b0;
    sup_we = 1'b0;
    sup_addr = 32'h5555_5555;
    sup_wdata = 32'haaaa_aaaa;
  end
  // Released lines show the inverse, so a stale value cannot pass for a held one
  task automatic acc(input logic we, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'h0000_0000;
    @(posedge sys_clk);
    #1;
    sup_req = 1'b1;
    sup_we = we;
    sup_addr = a;
    sup_wdata = d;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge sys_clk);
      if (sup_ack === 1'b1) begin
        ok = 1'b1;
        q = sup_rdata;
      end
    end
    #1;
    sup_req = 1'b0;
    sup_we = ~we;
    sup_addr = ~a;
    sup_wdata = ~d;
  endtask
endmodule // sev_host_model

/* sim/sev_event_report_tb.sv */
`timescale 1ns/1ps
module sev_event_report_tb;
  logic sys_clk, rst, sup_req, sup_we, ext_hit, sup_ack, irq, big_endian;
  logic [31:0] sup_addr, sup_wdata, sup_rdata, q;
  logic [7:0] rx_pending;
  logic [1:0] tx_mark_done;
  int bad_count = 0;
  int comparisons = 0;
  sev_event_report dut (.sys_clk(sys_clk), .rst(rst), .sup_req(sup_req), .sup_we(sup_we),
    .sup_addr(sup_addr), .sup_wdata(sup_wdata), .ext_hit(ext_hit), .rx_pending(rx_pending),
    .tx_mark_done(tx_mark_done), .sup_ack(sup_ack), .sup_rdata(sup_rdata), .irq(irq),
    .big_endian(big_endian));
  sev_host_model host (.sys_clk(sys_clk), .sup_ack(sup_ack), .sup_rdata(sup_rdata),
    .sup_req(sup_req), .sup_we(sup_we), .sup_addr(sup_addr), .sup_wdata(sup_wdata));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d);
    logic ok;
    host.acc(we, a, d, q, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: no acknowledge", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic t_reset();
    rd(sev_pkg::OFF_IND_MASK, 32'h0000_0000);
    rd(sev_pkg::OFF_INT_MASK, 32'hffff_0000);
    chk({30'h0, irq, big_endian}, 32'h0000_0000);
  endtask
  task automatic t_ind_mask();
    @(posedge sys_clk);
    #1 rx_pending = 8'ha5;
    rd(sev_pkg::OFF_FLAGS, 32'h00a5_0000);
    wr(sev_pkg::OFF_FLAGS, 32'hffff_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h00a5_0000);
    wr(sev_pkg::OFF_IND_MASK, 32'hffff_0000);
    rd(sev_pkg::OFF_IND_MASK, 32'h0000_0000);
    wr(sev_pkg::OFF_IND_SET, 32'h0005_0000);
    rd(sev_pkg::OFF_IND_MASK, 32'h0005_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h00a0_0000);
    wr(sev_pkg::OFF_IND_CLR, 32'h0001_0000);
    rd(sev_pkg::OFF_IND_MASK, 32'h0004_0000);
    wr(sev_pkg::OFF_IND_CLR, 32'hffff_0000);
    rx_pending = 8'h00;
    rd(sev_pkg::OFF_FLAGS, 32'h0000_0000);
  endtask
  task automatic t_marks();
    @(posedge sys_clk);
    #1 tx_mark_done = 2'b11;
    @(posedge sys_clk);
    #1 tx_mark_done = 2'b00;
    rd(sev_pkg::OFF_FLAGS, 32'hc000_0000);
    rd(sev_pkg::OFF_INT_VIEW, 32'h0000_0000);
    wr(sev_pkg::OFF_INT_MASK, 32'h0000_0000);
    rd(sev_pkg::OFF_INT_MASK, 32'hffff_0000);
    wr(sev_pkg::OFF_INT_CLR, 32'h8000_0000);
    rd(sev_pkg::OFF_INT_MASK, 32'h7fff_0000);
    rd(sev_pkg::OFF_INT_VIEW, 32'h8000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(sev_pkg::OFF_FLAGS, 32'h8000_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h4000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(sev_pkg::OFF_INT_SET, 32'h8000_0000);
    rd(sev_pkg::OFF_INT_MASK, 32'hffff_0000);
    wr(sev_pkg::OFF_FLAGS, 32'h4000_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h0000_0000);
    fork
      wr(sev_pkg::OFF_FLAGS, 32'hc000_0000);
      begin
        @(posedge sys_clk);
        #1 tx_mark_done = 2'b11;
        @(posedge sys_clk);
        #1 tx_mark_done = 2'b00;
      end
    join
    rd(sev_pkg::OFF_FLAGS, 32'hc000_0000);
    wr(sev_pkg::OFF_FLAGS, 32'hc000_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h0000_0000);
  endtask
  task automatic t_bad();
    rd(32'h000c_c500, 32'h0000_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h2000_0000);
    rd(32'h000c_c504, 32'h0000_0000);
    rd(sev_pkg::OFF_BAD_ADDR, 32'h000c_c500);
    wr(sev_pkg::OFF_FLAGS, 32'h0000_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h2000_0000);
    wr(sev_pkg::OFF_FLAGS, 32'h2000_0000);
    rd(sev_pkg::OFF_FLAGS, 32'h0000_0000);
    ext_hit = 1'b1;
    wr(32'h0000_0100, 32'h0000_0000);
    ext_hit = 1'b0;
    rd(sev_pkg::OFF_FLAGS, 32'h0000_0000);
  endtask
  task automatic t_endian();
    wr(sev_pkg::OFF_ENDIAN, 32'h8000_0000);
    chk({31'h0, big_endian}, 32'h0000_0001);
    rd(sev_pkg::OFF_ENDIAN, 32'h0000_0080);
    wr(sev_pkg::OFF_IND_SET, 32'h0000_0100);
    rd(sev_pkg::OFF_IND_MASK, 32'h0000_0100);
    wr(sev_pkg::OFF_IND_CLR, 32'h0000_0100);
    wr(sev_pkg::OFF_ENDIAN, 32'h0000_0080);
    chk({31'h0, big_endian}, 32'h0000_0001);
    wr(sev_pkg::OFF_ENDIAN, 32'h0000_0000);
    chk({31'h0, big_endian}, 32'h0000_0000);
  endtask
  task automatic t_rerst();
    wr(sev_pkg::OFF_IND_SET, 32'hffff_0000);
    wr(sev_pkg::OFF_ENDIAN, 32'h8000_0000);
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk({31'h0, big_endian}, 32'h0000_0000);
    rd(sev_pkg::OFF_IND_MASK, 32'h0000_0000);
    rd(sev_pkg::OFF_INT_MASK, 32'hffff_0000);
  endtask
  initial begin
    rst = 1'b1;
    ext_hit = 1'b0;
    rx_pending = 8'h00;
    tx_mark_done = 2'b00;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_reset();
    t_ind_mask();
    t_marks();
    t_bad();
    t_endian();
    t_rerst();
    close_out();
  end
endmodule // sev_event_report_tb
